// file: pkg/mace_pkg.sv
`default_nettype none
package mace_pkg;
  // --------------------------------------------------------------
  // register addresses on the i/o channel (10-bit decode)
  // --------------------------------------------------------------
  localparam logic [9:0] ADR_SYS  = 10'h07C;
  localparam logic [9:0] ADR_RXTX = 10'h3F8;
  localparam logic [9:0] ADR_IER  = 10'h3F9;
  localparam logic [9:0] ADR_IIR  = 10'h3FA;
  localparam logic [9:0] ADR_LCR  = 10'h3FB;
  localparam logic [9:0] ADR_MCR  = 10'h3FC;
  localparam logic [9:0] ADR_LSR  = 10'h3FD;
  localparam logic [9:0] ADR_MSR  = 10'h3FE;
  localparam logic [9:0] ADR_SCR  = 10'h3FF;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int LCR_RATE_LATCH_SELECT  = 7;
  localparam int LCR_BRK   = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EPS   = 4;
  localparam int LCR_PEN   = 3;
  localparam int LCR_STB   = 2;
  localparam int MCR_LOOP  = 4;
  localparam int MCR_OUT2  = 3;
  localparam int MCR_OUT1  = 2;
  localparam int MCR_RTS   = 1;
  localparam int MCR_DTR   = 0;
  localparam int SYS_PWR   = 1;
  localparam int IER_MS    = 3;
  localparam int IER_LS    = 2;
  localparam int IER_THRE  = 1;
  localparam int IER_RDA   = 0;
  // interrupt source codes, highest priority first
  localparam logic [1:0] IID_LS   = 2'h3;
  localparam logic [1:0] IID_RDA  = 2'h2;
  localparam logic [1:0] IID_THRE = 2'h1;
  localparam logic [1:0] IID_MS   = 2'h0;
  // --------------------------------------------------------------
  // bit timing in 16x ticks
  // --------------------------------------------------------------
  localparam logic [5:0] TICK_MID    = 6'h07;
  localparam logic [5:0] TICK_LAST   = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST  = 6'h1F;
  localparam logic [2:0] LEN_BASE    = 3'h4;
  // --------------------------------------------------------------
  // values after reset
  // --------------------------------------------------------------
  localparam logic [7:0] RST_LCR = 8'h00;
  localparam logic [4:0] RST_MCR = 5'h00;
  localparam logic [7:0] RST_SYS = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [3:0] RST_IER = 4'h0;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } mace_tx_st_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } mace_rx_st_t;
  typedef struct packed {
    logic [7:0] ad;
    logic [1:0] a_hi;
    logic       ale;
    logic       ior_n;
    logic       iow_n;
    logic       aen;
    logic       upper_zero;
  } mace_bus_in_t;
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } mace_mdm_in_t;
  typedef struct packed {
    logic out2;
    logic out1;
    logic rts;
    logic dtr;
  } mace_mdm_out_t;
  typedef struct packed {
    mace_bus_in_t bus;
    mace_mdm_in_t mdm;
    logic         rxd;
    logic         rclk;
  } mace_sync_t;
  localparam mace_sync_t SYNC_RST = '{
    bus: '{ad: 8'h00, a_hi: 2'h0, ale: 1'b0, ior_n: 1'b1,
           iow_n: 1'b1, aen: 1'b1, upper_zero: 1'b0},
    mdm: 4'h0, rxd: 1'b1, rclk: 1'b0};
  typedef struct packed {
    mace_sync_t  s1, s2, s3, flt;
    logic [9:0]  adr;
    logic        rd_oe, wr_q;
    logic [7:0]  rdat, sys, lcr, scr, dll, dlm, thr, rbr;
    logic [3:0]  ier;
    logic [4:0]  mcr;
    logic [15:0] bcnt;
    logic        thr_full, thre_pend, dr, oe, pe, fe, bi;
    logic [3:0]  msi_q, msd;
    mace_tx_st_t tx_st;
    logic [7:0]  tx_sh;
    logic [5:0]  tcnt;
    logic [2:0]  tidx;
    logic        tpar, txd;
    mace_rx_st_t rx_st;
    logic [7:0]  rx_sh;
    logic [5:0]  rcnt;
    logic [2:0]  ridx;
    logic        rpar, rzero;
  } mace_state_t;
endpackage : mace_pkg
`default_nettype wire

// file: src/mace_top.sv
`timescale 1ns/1ns
`default_nettype none
module mace_top (
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  input  wire mace_pkg::mace_bus_in_t  bus_i,
  output logic [7:0]                   ad_o,
  output logic                         ad_oe_o,
  output logic                         irq_o,
  input  wire mace_pkg::mace_mdm_in_t  mdm_i,
  output mace_pkg::mace_mdm_out_t      mdm_o,
  input  wire logic                    rxd_i,
  output logic                         txd_o,
  input  wire logic                    rate_clk_i,
  output logic                         modem_power_o
);
  import mace_pkg::*;

  mace_state_t r;
  mace_state_t n;
  mace_sync_t  raw;
  mace_sync_t  fn;
  logic        rate_latch_select, loop, sel, hit, rd_start, wr_start, rd_now, wr_now;
  logic [15:0] div;
  logic        b16, rise;
  logic [3:0]  msi;
  logic        ls_src, rda_src, thre_src, ms_src, pend;
  logic [1:0]  iid;
  logic [2:0]  len_last;
  logic [5:0]  stop_last;
  logic        ptx, txl, rxin;
  logic [7:0]  rdv;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------
  // input filtering and decode
  // --------------------------------------------------------------
  // a bit only moves once stages two and three agree
  assign raw = '{bus: bus_i, mdm: mdm_i, rxd: rxd_i, rclk: rate_clk_i};
  assign fn  = mace_sync_t'((r.s3 & ~(r.s2 ^ r.s3))
                            | (r.flt & (r.s2 ^ r.s3)));
  assign rate_latch_select = r.lcr[LCR_RATE_LATCH_SELECT];
  assign loop = r.mcr[MCR_LOOP];
  // only the upper-zero flag stands in for address bits 15..10
  assign sel  = fn.bus.upper_zero & ~fn.bus.aen;
  assign hit  = (r.adr == ADR_SYS) || (r.adr[9:3] == ADR_RXTX[9:3]);
  assign rd_now   = sel & hit & ~fn.bus.ior_n;
  assign wr_now   = sel & hit & ~fn.bus.iow_n;
  assign rd_start = rd_now & ~r.rd_oe;
  assign wr_start = wr_now & ~r.wr_q;

  // --------------------------------------------------------------
  // rate generator
  // --------------------------------------------------------------
  // a zero divisor halts the ticks until software loads it
  assign div  = {r.dlm, r.dll};
  assign rise = fn.rclk & ~r.flt.rclk;
  assign b16  = rise & (div != 16'h0000) & (r.bcnt <= 16'h0001);

  // --------------------------------------------------------------
  // modem status and interrupt priority
  // --------------------------------------------------------------
  // loopback feeds control outputs back as inputs
  assign msi = loop ? {r.mcr[MCR_OUT2], r.mcr[MCR_OUT1],
                       r.mcr[MCR_DTR], r.mcr[MCR_RTS]}
                    : {fn.mdm.dcd, fn.mdm.ri, fn.mdm.dsr, fn.mdm.cts};
  // disabled sources never reach the code
  assign ls_src   = r.ier[IER_LS] & (r.oe | r.pe | r.fe | r.bi);
  assign rda_src  = r.ier[IER_RDA] & r.dr;
  assign thre_src = r.ier[IER_THRE] & r.thre_pend;
  assign ms_src   = r.ier[IER_MS] & (|r.msd);
  assign pend     = ls_src | rda_src | thre_src | ms_src;
  // fixed priority, bit 2 marks the receive-side sources
  assign iid = ls_src  ? IID_LS  :
               rda_src ? IID_RDA :
               thre_src ? IID_THRE : IID_MS;
  assign irq_o = pend & r.mcr[MCR_OUT2];

  // --------------------------------------------------------------
  // character format
  // --------------------------------------------------------------
  assign len_last = LEN_BASE + {1'b0, r.lcr[1:0]};
  // one, one and a half or two stop bits
  assign stop_last = !r.lcr[LCR_STB] ? TICK_LAST :
                     (r.lcr[1:0] == 2'h0) ? STOP15_LAST : STOP2_LAST;
  // stick bit clear forces a space parity bit
  assign ptx = r.lcr[LCR_STICK] & (r.tpar ^ ~r.lcr[LCR_EPS]);
  // break overrides whatever the shifter is doing
  assign txl = r.lcr[LCR_BRK] ? 1'b0 :
               (r.tx_st == TX_START) ? 1'b0 :
               (r.tx_st == TX_DATA) ? r.tx_sh[0] :
               (r.tx_st == TX_PAR) ? ptx : 1'b1;
  assign rxin = loop ? txl : fn.rxd;

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // loopback keeps the link idle and the handshake lines off
  assign ad_o    = r.rdat;
  assign ad_oe_o = r.rd_oe;
  assign txd_o   = r.txd;
  assign mdm_o   = loop ? 4'h0 : {r.mcr[MCR_OUT2], r.mcr[MCR_OUT1],
                                  r.mcr[MCR_RTS], r.mcr[MCR_DTR]};
  assign modem_power_o = r.sys[SYS_PWR];

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.flt = fn;
    n.rd_oe = rd_now;
    n.wr_q = wr_now;
    if (fn.bus.ale) begin
      n.adr = {fn.bus.a_hi, fn.bus.ad};
    end
    // read data mux, reserved bits read zero
    case (r.adr)
      ADR_RXTX: rdv = rate_latch_select ? r.dll : r.rbr;
      ADR_IER:  rdv = rate_latch_select ? r.dlm : {4'h0, r.ier};
      ADR_IIR:  rdv = {5'h00, iid, pend};
      ADR_LCR:  rdv = r.lcr;
      ADR_MCR:  rdv = {3'h0, r.mcr};
      ADR_LSR:  rdv = {1'b0, ~r.thr_full & (r.tx_st == TX_IDLE),
                       ~r.thr_full, r.bi, r.fe, r.pe, r.oe, r.dr};
      ADR_MSR:  rdv = {r.msi_q, r.msd};
      ADR_SCR:  rdv = r.scr;
      ADR_SYS:  rdv = r.sys;
      default:  rdv = 8'h00;
    endcase
    // read side effects go first so hardware sets below win
    if (rd_start) begin
      n.rdat = rdv;
      case (r.adr)
        ADR_RXTX: begin
          if (!rate_latch_select) begin
            n.dr = 1'b0;
          end
        end
        ADR_IIR: begin
          if (pend && iid == IID_THRE) begin
            n.thre_pend = 1'b0;
          end
        end
        ADR_LSR: begin
          n.oe = 1'b0;
          n.pe = 1'b0;
          n.fe = 1'b0;
          n.bi = 1'b0;
        end
        ADR_MSR: begin
          n.msd = 4'h0;
        end
        default: begin
        end
      endcase
    end
    // rate counter
    if (rise) begin
      n.bcnt = b16 ? div : r.bcnt - 16'h0001;
    end
    // transmitter
    n.txd = loop ? 1'b1 : txl;
    case (r.tx_st)
      TX_IDLE: begin
        if (r.thr_full) begin
          n.tx_sh = r.thr;
          n.thr_full = 1'b0;
          n.thre_pend = 1'b1;
          n.tcnt = 6'h00;
          n.tidx = 3'h0;
          n.tpar = 1'b0;
          n.tx_st = TX_START;
        end
      end
      TX_START: begin
        if (b16) begin
          n.tcnt = r.tcnt + 6'h01;
          if (r.tcnt == TICK_LAST) begin
            n.tcnt = 6'h00;
            n.tx_st = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (b16) begin
          n.tcnt = r.tcnt + 6'h01;
          if (r.tcnt == TICK_LAST) begin
            // shift right so bit 0 leaves first
            n.tcnt = 6'h00;
            n.tx_sh = {1'b0, r.tx_sh[7:1]};
            n.tpar = r.tpar ^ r.tx_sh[0];
            n.tidx = r.tidx + 3'h1;
            if (r.tidx == len_last) begin
              n.tx_st = r.lcr[LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (b16) begin
          n.tcnt = r.tcnt + 6'h01;
          if (r.tcnt == TICK_LAST) begin
            n.tcnt = 6'h00;
            n.tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (b16) begin
          n.tcnt = r.tcnt + 6'h01;
          if (r.tcnt == stop_last) begin
            n.tcnt = 6'h00;
            n.tx_st = TX_IDLE;
          end
        end
      end
      default: n.tx_st = TX_IDLE;
    endcase
    // register writes
    if (wr_start) begin
      case (r.adr)
        ADR_RXTX: begin
          if (rate_latch_select) begin
            n.dll = fn.bus.ad;
            n.bcnt = {r.dlm, fn.bus.ad};
          end else begin
            n.thr = fn.bus.ad;
            n.thr_full = 1'b1;
            n.thre_pend = 1'b0;
          end
        end
        ADR_IER: begin
          if (rate_latch_select) begin
            n.dlm = fn.bus.ad;
            n.bcnt = {fn.bus.ad, r.dll};
          end else begin
            n.ier = fn.bus.ad[3:0];
          end
        end
        ADR_LCR: n.lcr = fn.bus.ad;
        ADR_MCR: n.mcr = fn.bus.ad[4:0];
        ADR_SCR: n.scr = fn.bus.ad;
        ADR_SYS: n.sys = fn.bus.ad;
        default: begin
        end
      endcase
    end
    // receiver, sampled mid-bit
    case (r.rx_st)
      RX_IDLE: begin
        if (!rxin) begin
          n.rcnt = 6'h00;
          n.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (b16) begin
          n.rcnt = r.rcnt + 6'h01;
          if (r.rcnt == TICK_MID) begin
            // a glitch shorter than half a bit is dropped
            n.rcnt = 6'h00;
            n.ridx = 3'h0;
            n.rx_sh = 8'h00;
            n.rpar = 1'b0;
            n.rzero = 1'b1;
            n.rx_st = rxin ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (b16) begin
          n.rcnt = r.rcnt + 6'h01;
          if (r.rcnt == TICK_LAST) begin
            n.rcnt = 6'h00;
            n.rx_sh[r.ridx] = rxin;
            n.rpar = r.rpar ^ rxin;
            n.rzero = r.rzero & ~rxin;
            n.ridx = r.ridx + 3'h1;
            if (r.ridx == len_last) begin
              n.rx_st = r.lcr[LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (b16) begin
          n.rcnt = r.rcnt + 6'h01;
          if (r.rcnt == TICK_LAST) begin
            n.rcnt = 6'h00;
            n.rzero = r.rzero & ~rxin;
            if (rxin != (r.lcr[LCR_STICK]
                         & (r.rpar ^ ~r.lcr[LCR_EPS]))) begin
              n.pe = 1'b1;
            end
            n.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (b16) begin
          n.rcnt = r.rcnt + 6'h01;
          if (r.rcnt == TICK_LAST) begin
            // only the first stop bit is checked
            n.rcnt = 6'h00;
            n.fe = n.fe | ~rxin;
            n.bi = n.bi | (r.rzero & ~rxin);
            n.oe = n.oe | n.dr;
            n.rbr = r.rx_sh;
            n.dr = 1'b1;
            n.rx_st = RX_IDLE;
          end
        end
      end
      default: n.rx_st = RX_IDLE;
    endcase
    // change flags: set after the read clear so an edge is kept
    n.msi_q = msi;
    n.msd = n.msd | {msi[3] ^ r.msi_q[3], r.msi_q[2] & ~msi[2],
                     msi[1] ^ r.msi_q[1], msi[0] ^ r.msi_q[0]};
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, flt: SYNC_RST,
             lcr: RST_LCR, mcr: RST_MCR, sys: RST_SYS, dll: RST_DIV,
             dlm: RST_DIV, ier: RST_IER, tx_st: TX_IDLE,
             rx_st: RX_IDLE, txd: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  brk_hold_a: assert property (
    (r.lcr[LCR_BRK] && !loop) |=> !txd_o)
    else $error("break not holding the line low");
  irq_gate_a: assert property (
    !r.mcr[MCR_OUT2] |-> !irq_o)
    else $error("interrupt passed with gate off");
  ier_off_a: assert property (
    (r.ier == 4'h0) |-> (!irq_o && iid == IID_MS))
    else $error("disabled source raised a request");
  div_load_a: assert property (
    (wr_start && rate_latch_select && r.adr == ADR_RXTX)
      |=> (r.bcnt == {r.dlm, r.dll}))
    else $error("rate counter not reloaded");
  dr_set_a: assert property (
    (r.rx_st == RX_STOP && b16 && r.rcnt == TICK_LAST)
      |=> (r.dr && r.rbr == $past(r.rx_sh)))
    else $error("data ready not set on character");
  lcr_read_a: assert property (
    (rd_start && r.adr == ADR_LCR) |=> (ad_o == $past(r.lcr)))
    else $error("line control read mismatch");
  ier_zero_a: assert property (
    (rd_start && !rate_latch_select && r.adr == ADR_IER) |=> (ad_o[7:4] == 4'h0))
    else $error("enable upper bits not zero");
  iir_code_a: assert property (
    (rd_start && r.adr == ADR_IIR)
      |=> (ad_o[7:3] == 5'h00 && ad_o[0] == $past(|r.msd && r.ier[3]
           || (r.dr && r.ier[0]) || (r.thre_pend && r.ier[1])
           || ((r.oe | r.pe | r.fe | r.bi) && r.ier[2]))))
    else $error("identification value wrong");
  lsb_first_a: assert property (
    (r.tx_st == TX_DATA && !r.lcr[LCR_BRK] && !loop)
      |=> (txd_o == $past(r.tx_sh[0])))
    else $error("data bit order wrong");
  loop_msr_a: assert property (
    (rd_start && loop && r.adr == ADR_MSR)
      |=> (ad_o[7:4] == $past({r.mcr[3], r.mcr[2], r.mcr[0], r.mcr[1]})))
    else $error("loopback status mismatch");
endmodule : mace_top
`default_nettype wire

// file: sim/mace_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// host processor on the i/o channel
// ------------------------------------------------------------
module mace_host (
  input  wire logic              clock_i,
  input  wire logic [7:0]        ad_i,
  input  wire logic              ad_oe_i,
  output mace_pkg::mace_bus_in_t bus_o
);
  import mace_pkg::*;
  // idle bus with select allowed
  initial begin
    bus_o = SYNC_RST.bus;
    bus_o.aen = 1'b0;
  end
  // address phase; strobe waits for ale low so the latch settles
  task automatic adr(input logic [15:0] a);
    @(negedge clock_i);
    bus_o.ad = a[7:0];
    bus_o.a_hi = a[9:8];
    bus_o.upper_zero = (a[15:10] == 6'h00);
    bus_o.ale = 1'b1;
    repeat (6) @(negedge clock_i);
    bus_o.ale = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : adr
  // write: strobe low 8 cycles, then high 8 cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    adr(a);
    bus_o.ad = d;
    bus_o.iow_n = 1'b0;
    repeat (8) @(negedge clock_i);
    bus_o.iow_n = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask : wr
  // read: released ad shows the inverse so stale data cannot match
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    adr(a);
    bus_o.ad = ~bus_o.ad;
    bus_o.ior_n = 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(negedge clock_i);
      if (ad_oe_i === 1'b1) begin
        d = ad_i;
        ok = 1'b1;
      end
    end
    repeat (4) @(negedge clock_i);
    bus_o.ior_n = 1'b1;
    repeat (8) @(negedge clock_i);
  endtask : rd
endmodule : mace_host
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// register and serial checks
// ------------------------------------------------------------
module tb;
  import mace_pkg::*;
  localparam int BIT_NS = 16 * 542;
  logic clock_i = 1'b0, rst_i = 1'b1, rxd_i = 1'b1, rate_clk_i = 1'b0;
  logic [7:0] ad_o, d;
  logic ad_oe_o, irq_o, txd_o, modem_power_o;
  logic [9:0] v;
  mace_bus_in_t hb, bus;
  mace_mdm_in_t mdm_i = '0;
  mace_mdm_out_t mdm_o;
  int n_errors = 0, check_count = 0;
  always #5 clock_i = ~clock_i;
  always #271 rate_clk_i = ~rate_clk_i;
  // pin level: device wins while it drives
  always_comb begin
    bus = hb;
    if (ad_oe_o) bus.ad = ad_o;
  end
  mace_top i_mace_top (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus),
    .ad_o(ad_o), .ad_oe_o(ad_oe_o), .irq_o(irq_o), .mdm_i(mdm_i),
    .mdm_o(mdm_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .rate_clk_i(rate_clk_i), .modem_power_o(modem_power_o));
  mace_host i_mace_host (.clock_i(clock_i), .ad_i(ad_o),
    .ad_oe_i(ad_oe_o), .bus_o(hb));
  task automatic give_verdict;
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // a read that never gets an answer ends the run
  task automatic rdv(input logic [15:0] a, output logic [7:0] q);
    logic ok;
    i_mace_host.rd(a, q, ok);
    if (!ok) begin
      n_errors++;
      $display("Error read %h expected answer seen none", a);
      give_verdict;
    end
  endtask : rdv
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    rdv(a, q);
    chk("register", e, q);
  endtask : rdc
  // send one byte and sample each bit mid-cell
  task automatic grab(input logic [7:0] b);
    i_mace_host.wr({6'h00, ADR_RXTX}, b);
    for (int i = 0; i < 3000 && txd_o === 1'b1; i++) @(negedge clock_i);
    if (txd_o !== 1'b0) lapse("tx start");
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 10; i++) begin
      v[i] = txd_o;
      #(BIT_NS);
    end
  endtask : grab
  // a wait that runs out ends the run
  task automatic lapse(input string nm);
    n_errors++;
    $display("Error %s expected event seen timeout", nm);
    give_verdict;
  endtask : lapse
  // lengths in clock cycles, within 40 cycles either way
  task automatic chk_len(input string nm, input int e, input int g);
    check_count++;
    if (g < e - 40 || g > e + 40) begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_len
  // two zero bytes back to back: the gap is the first stop, the next
  // low run is start plus data bits; lengths given in half bits
  task automatic span(input logic [7:0] f, input int lo_h, input int hi_h);
    int h = 0;
    int l = 0;
    i_mace_host.wr({6'h00, ADR_LCR}, f);
    i_mace_host.wr({6'h00, ADR_RXTX}, 8'h00);
    i_mace_host.wr({6'h00, ADR_RXTX}, 8'h00);
    for (int i = 0; i < 12000 && txd_o !== 1'b1; i++) @(negedge clock_i);
    if (txd_o !== 1'b1) lapse("stop start");
    for (h = 0; h < 5000 && txd_o === 1'b1; h++) @(negedge clock_i);
    if (h == 5000) lapse("stop end");
    for (l = 0; l < 10000 && txd_o === 1'b0; l++) @(negedge clock_i);
    if (l == 10000) lapse("data end");
    chk_len("stop length", hi_h * BIT_NS / 20, h);
    chk_len("data length", lo_h * BIT_NS / 20, l);
    // let the second stop finish before the format changes
    repeat (2000) @(negedge clock_i);
  endtask : span
  // parity setting per frame: even+computed, odd+computed, space
  logic [7:0] fmt [3] = '{8'h3B, 8'h2B, 8'h1B};
  logic par [3] = '{1'b1, 1'b0, 1'b0};
  initial begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    rdc({6'h00, ADR_LCR}, RST_LCR);
    chk("txd idle", 8'h01, {7'h00, txd_o});
    i_mace_host.wr({6'h00, ADR_SCR}, 8'hA5);
    i_mace_host.wr(16'h13FF, 8'h77);
    rdc({6'h00, ADR_SCR}, 8'hA5);
    i_mace_host.wr({6'h00, ADR_SYS}, 8'h02);
    chk("power", 8'h01, {7'h00, modem_power_o});
    rdc({6'h00, ADR_SYS}, 8'h02);
    i_mace_host.wr({6'h00, ADR_LCR}, 8'h80);
    i_mace_host.wr({6'h00, ADR_RXTX}, 8'h01);
    i_mace_host.wr({6'h00, ADR_IER}, 8'h00);
    rdc({6'h00, ADR_RXTX}, 8'h01);
    rdc({6'h00, ADR_IER}, 8'h00);
    i_mace_host.wr({6'h00, ADR_LCR}, 8'h03);
    i_mace_host.wr({6'h00, ADR_IER}, 8'hFF);
    rdc({6'h00, ADR_IER}, 8'h0F);
    rdc({6'h00, ADR_LCR}, 8'h03);
    i_mace_host.wr({6'h00, ADR_MCR}, 8'h0D);
    chk("handshake out", 8'h0D, {4'h0, mdm_o});
    i_mace_host.wr({6'h00, ADR_MCR}, 8'h00);
    i_mace_host.wr({6'h00, ADR_IER}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      i_mace_host.wr({6'h00, ADR_LCR}, fmt[k]);
      grab(8'hA7);
      chk("tx data", 8'hA7, v[7:0]);
      chk("tx parity", {7'h00, par[k]}, {7'h00, v[8]});
      chk("tx stop", 8'h01, {7'h00, v[9]});
    end
    span(8'h04, 12, 3);
    span(8'h06, 16, 4);
    i_mace_host.wr({6'h00, ADR_LCR}, 8'h43);
    chk("break", 8'h00, {7'h00, txd_o});
    i_mace_host.wr({6'h00, ADR_LCR}, 8'h03);
    rdc({6'h00, ADR_IIR}, 8'h00);
    i_mace_host.wr({6'h00, ADR_IER}, 8'h02);
    chk("irq gated", 8'h00, {7'h00, irq_o});
    i_mace_host.wr({6'h00, ADR_MCR}, 8'h08);
    chk("irq", 8'h01, {7'h00, irq_o});
    rdc({6'h00, ADR_IIR}, 8'h03);
    rdc({6'h00, ADR_IIR}, 8'h00);
    i_mace_host.wr({6'h00, ADR_MCR}, 8'hFF);
    rdc({6'h00, ADR_MCR}, 8'h1F);
    i_mace_host.wr({6'h00, ADR_MCR}, 8'h15);
    rdv({6'h00, ADR_MSR}, d);
    chk("loop mirror", 8'h06, {4'h0, d[7:4]});
    chk("msr change", 8'h0B, {4'h0, d[3:0]});
    chk("loop handshake", 8'h00, {4'h0, mdm_o});
    rdc({6'h00, ADR_MSR}, 8'h60);
    i_mace_host.wr({6'h00, ADR_IER}, 8'h01);
    i_mace_host.wr({6'h00, ADR_RXTX}, 8'h3C);
    d = 8'h00;
    for (int i = 0; i < 60 && d[0] !== 1'b1; i++) begin
      repeat (300) @(negedge clock_i);
      rdv({6'h00, ADR_LSR}, d);
    end
    if (d[0] !== 1'b1) lapse("receive");
    chk("data ready", 8'h01, {7'h00, d[0]});
    rdc({6'h00, ADR_IIR}, 8'h05);
    rdc({6'h00, ADR_RXTX}, 8'h3C);
    rdc({6'h00, ADR_IIR}, 8'h00);
    give_verdict;
  end
endmodule : tb
`default_nettype wire
